// File: shared/ibd_defines.vh
/* Offsets, fields, resets, codes and counts of the device port.
   Assumes inclusion by the design file; definitions only. */
`ifndef IBD_DEFINES_VH
`define IBD_DEFINES_VH

// Register byte offsets
`define IBD_REG_CTRL      8'h00
`define IBD_REG_ADDR      8'h04
`define IBD_REG_STATE     8'h08
`define IBD_REG_TXDATA    8'h0c
`define IBD_REG_RXDATA    8'h10
`define IBD_REG_SPOLL     8'h14
`define IBD_REG_IRQSTAT   8'h18
`define IBD_REG_IRQMASK   8'h1c
`define IBD_REG_PANEL     8'h20

// Control register fields; address register reset value and maximum
`define IBD_CTRL_ENABLE   0
`define IBD_CTRL_TALKONLY 1
`define IBD_ADDR_RESET    5'h01
`define IBD_ADDR_MAX      5'h1e

// State register fields
`define IBD_ST_TALKER     0
`define IBD_ST_LISTENER   1
`define IBD_ST_REMOTE     2
`define IBD_ST_LOCKOUT    3
`define IBD_ST_SPOLL      4
`define IBD_ST_SRQ        5
`define IBD_ST_RXVALID    6
`define IBD_ST_TXBUSY     7

// Status byte field that requests service
`define IBD_SPOLL_RSV     6
// Transmit register field marking the last byte
`define IBD_TX_EOI        8

// Interrupt status and mask fields
`define IBD_IRQ_RXBYTE    0
`define IBD_IRQ_TXDONE    1
`define IBD_IRQ_OUTDUE    2
`define IBD_IRQ_DEVCLR    3
`define IBD_IRQ_TRIGGER   4
`define IBD_IRQ_REMOTE    5
`define IBD_IRQ_WIDTH     6

// Commands, taken with attention asserted
`define IBD_CMD_GTL       8'h01
`define IBD_CMD_SDC       8'h04
`define IBD_CMD_GET       8'h08
`define IBD_CMD_LLO       8'h11
`define IBD_CMD_DCL       8'h14
`define IBD_CMD_SPE       8'h18
`define IBD_CMD_SPD       8'h19
`define IBD_CMD_LISTEN    3'b001
`define IBD_CMD_TALK      3'b010
`define IBD_CMD_UNL       8'h3f
`define IBD_CMD_UNT       8'h5f

// Output data request, as listener data
`define IBD_ODR_CHAR0     8'h4f
`define IBD_ODR_CHAR1     8'h44

// Data settles 2 us before dav; count at 40 MHz
`define IBD_SETTLE_CYC    8'h50

`endif

// File: src/ibd_device_port.v
/*
 * Instrument bus device port with
 * Wishbone registers and one interrupt.
 *
 * Assumes bus pins arrive async in true
 * logic, an outside driver stage that
 * pulls a line while its enable is high,
 * and panel strobes on clk.
 */
// The register offsets and the Wishbone slave port were left to the implementer.
//
// Behaviour
// - Bus address 0 to 30 for talker and listener; talk-only selectable.
// - Bus address resets to 1.
// - Full source and acceptor three-wire byte handshakes.
// - Talker sends, answers serial polls, untalks on own listen address.
// - Listener receives, unlistens on own talk address; no listen-only.
// - Service request asserted; status byte reported on serial poll.
// - No parallel poll response and no controller function.
// - Remote enable moves the device from local to remote.
// - Go-to-local in remote returns the device to local.
// - In remote only the local key works, unless locked out.
// - Local lockout disables the local key.
// - Interface clear drops talker and listener addressed states.
// - Device clear flushes buffers and errors; setup kept.
// - Group trigger while holding a sample refreshes the display.
// - Addressable mode sends data after an output data request.
// - Talk-only sends data each display update; controller ignored.
// - Interface comes up disabled until switched on.
// - Talker can send setup, status byte and error codes.
`include "ibd_defines.vh"
`default_nettype none

module ibd_device_port (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Wishbone classic slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output wire        irq,
    // Bus data lines
    input  wire [7:0]  dioIn,
    output reg  [7:0]  dioOut,
    output reg         dioOe,
    // Bus handshake and management lines
    input  wire        davIn,
    output reg         davOut,
    output reg         davOe,
    input  wire        nrfdIn,
    output reg         nrfdOut,
    output reg         nrfdOe,
    input  wire        ndacIn,
    output reg         ndacOut,
    output reg         ndacOe,
    input  wire        eoiIn,
    output reg         eoiOut,
    output reg         eoiOe,
    output reg         srqOut,
    output reg         srqOe,
    input  wire        atnIn,
    input  wire        ifcIn,
    input  wire        renIn,
    // Front panel and display
    input  wire        localKey,
    input  wire        displayTick,
    input  wire        sampleHold,
    output reg         panelKeysEnabled,
    output reg         displayRefresh
);

    localparam [3:0] SRC_IDLE   = 4'h1;
    localparam [3:0] SRC_SETTLE = 4'h2;
    localparam [3:0] SRC_DAV    = 4'h4;
    localparam [3:0] SRC_END    = 4'h8;
    localparam [2:0] ACC_READY  = 3'h1;
    localparam [2:0] ACC_TAKE   = 3'h2;
    localparam [2:0] ACC_WAIT   = 3'h4;
    localparam [7:0] SETTLE_CYC = `IBD_SETTLE_CYC;

    // Command byte is our address of the given kind
    function addrHit;
        input [7:0] cmd;
        input [2:0] kind;
        input [4:0] mine;
        begin
            addrHit = (cmd[7:5] == kind) && (cmd[4:0] == mine);
        end
    endfunction

    // Two-flop synchronisers; stage one is read only by stage two
    reg [14:0] syncA;
    reg [14:0] syncB;
    always @(posedge clk) begin
        syncA <= {dioIn, davIn, nrfdIn, ndacIn, eoiIn, atnIn, ifcIn, renIn};
        syncB <= syncA;
    end
    wire [7:0] dioS  = syncB[14:7];
    wire       davS  = syncB[6];
    wire       nrfdS = syncB[5];
    wire       ndacS = syncB[4];
    wire       eoiS  = syncB[3];
    wire       atnS  = syncB[2];
    wire       ifcS  = syncB[1];
    wire       renS  = syncB[0];

    // Registers
    reg        enable;
    reg        talkOnly;
    reg [4:0]  busAddr;
    reg [7:0]  spollByte;
    reg [8:0]  txData;
    reg        txValid;
    reg [7:0]  rxData;
    reg        rxValid;
    reg [5:0]  irqStat;
    reg [5:0]  irqMask;
    // Interface state
    reg        talker;
    reg        listener;
    reg        remote;
    reg        lockout;
    reg        spollMode;
    reg        odrSeen;
    reg [3:0]  srcState;
    reg [2:0]  accState;
    reg [7:0]  settleCnt;
    reg        srcSpoll;
    // Event strobes of this cycle
    reg [5:0]  evt;

    wire busReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire busWrite = busReq && wb_we_i && wb_sel_i[0];
    wire controlled = enable && !talkOnly;
    wire talkActive = enable && (talkOnly || (talker && !atnS));
    wire accActive  = controlled && (atnS || listener);
    wire canAccept  = atnS || !rxValid;
    wire srcHasByte = (spollMode && talker) || txValid;

    // Acceptor handshake and command decode
    reg [7:0] cmd;
    always @(posedge clk) begin
        if (rst || !accActive) begin
            accState <= ACC_READY;
        end else begin
            case (accState)
                ACC_READY: if (davS && canAccept) accState <= ACC_TAKE;
                ACC_TAKE:  accState <= ACC_WAIT;
                ACC_WAIT:  if (!davS) accState <= ACC_READY;
                default:   accState <= ACC_READY;
            endcase
        end
    end
    wire accTake = accActive && (accState == ACC_READY) && davS && canAccept;

    always @* begin
        cmd = dioS;
    end

    wire panelKeyOk = localKey && remote && !lockout;
    wire devClear = accTake && atnS &&
                    ((cmd == `IBD_CMD_DCL) ||
                     (cmd == `IBD_CMD_SDC && listener));
    wire srcDone = (srcState == SRC_DAV) && ndacS;

    always @(posedge clk) begin
        if (rst) begin
            talker    <= 1'b0;
            listener  <= 1'b0;
            remote    <= 1'b0;
            lockout   <= 1'b0;
            spollMode <= 1'b0;
            odrSeen   <= 1'b0;
            rxData    <= 8'h00;
            rxValid   <= 1'b0;
            displayRefresh <= 1'b0;
            evt       <= 6'h00;
        end else begin
            evt <= 6'h00;
            displayRefresh <= 1'b0;
            if (busReq && !wb_we_i && wb_adr_i == `IBD_REG_RXDATA)
                rxValid <= 1'b0;
            if (!controlled || ifcS) begin
                talker    <= 1'b0;
                listener  <= 1'b0;
                spollMode <= 1'b0;
            end else if (accTake && atnS) begin
                if (addrHit(cmd, `IBD_CMD_LISTEN, busAddr)) begin
                    listener <= 1'b1;
                    talker   <= 1'b0;
                    if (renS && !remote) begin
                        remote <= 1'b1;
                        evt[`IBD_IRQ_REMOTE] <= 1'b1;
                    end
                end else if (addrHit(cmd, `IBD_CMD_TALK, busAddr)) begin
                    talker   <= 1'b1;
                    listener <= 1'b0;
                end else if (cmd == `IBD_CMD_UNL) begin
                    listener <= 1'b0;
                end else if (cmd == `IBD_CMD_UNT) begin
                    talker <= 1'b0;
                end else if (cmd == `IBD_CMD_SPE) begin
                    spollMode <= 1'b1;
                end else if (cmd == `IBD_CMD_SPD) begin
                    spollMode <= 1'b0;
                end else if (cmd == `IBD_CMD_LLO) begin
                    lockout <= 1'b1;
                end else if (cmd == `IBD_CMD_GTL && listener && remote) begin
                    remote <= 1'b0;
                    evt[`IBD_IRQ_REMOTE] <= 1'b1;
                end else if (cmd == `IBD_CMD_GET && listener) begin
                    evt[`IBD_IRQ_TRIGGER] <= 1'b1;
                    displayRefresh <= sampleHold;
                end
                // Parallel poll commands fall through unanswered
            end
            if (accTake && !atnS) begin
                rxData  <= cmd;
                rxValid <= 1'b1;
                evt[`IBD_IRQ_RXBYTE] <= 1'b1;
                odrSeen <= (cmd == `IBD_ODR_CHAR0);
                if (odrSeen && cmd == `IBD_ODR_CHAR1)
                    evt[`IBD_IRQ_OUTDUE] <= 1'b1;
            end
            if (devClear) begin
                rxValid <= 1'b0;
                odrSeen <= 1'b0;
                evt[`IBD_IRQ_DEVCLR] <= 1'b1;
            end
            if (enable && talkOnly && displayTick)
                evt[`IBD_IRQ_OUTDUE] <= 1'b1;
            if (srcDone)
                evt[`IBD_IRQ_TXDONE] <= 1'b1;
            if (!renS || !controlled) begin
                lockout <= 1'b0;
                if (remote)
                    evt[`IBD_IRQ_REMOTE] <= 1'b1;
                remote <= 1'b0;
            end else if (panelKeyOk) begin
                remote <= 1'b0;
                evt[`IBD_IRQ_REMOTE] <= 1'b1;
            end
        end
    end

    // Source handshake
    always @(posedge clk) begin
        if (rst || !talkActive || devClear) begin
            srcState  <= SRC_IDLE;
            settleCnt <= 8'h00;
            srcSpoll  <= 1'b0;
            dioOut    <= 8'h00;
            eoiOut    <= 1'b0;
        end else begin
            case (srcState)
                SRC_IDLE: if (srcHasByte) begin
                    srcSpoll  <= spollMode && talker;
                    if (spollMode && talker) begin
                        dioOut <= spollByte;
                        eoiOut <= 1'b0;
                    end else begin
                        dioOut <= txData[7:0];
                        eoiOut <= txData[`IBD_TX_EOI];
                    end
                    settleCnt <= SETTLE_CYC;
                    srcState  <= SRC_SETTLE;
                end
                SRC_SETTLE: begin
                    if (settleCnt != 8'h00)
                        settleCnt <= settleCnt - 8'h01;
                    else if (!nrfdS && !ndacS)
                        srcState <= SRC_DAV;
                end
                SRC_DAV:  if (ndacS) srcState <= SRC_END;
                SRC_END:  if (!ndacS || !nrfdS) srcState <= SRC_IDLE;
                default:  srcState <= SRC_IDLE;
            endcase
        end
    end

    // Pin drive; lines are released while the interface is off
    always @(posedge clk) begin
        if (rst) begin
            dioOe   <= 1'b0;
            davOut  <= 1'b0;
            davOe   <= 1'b0;
            nrfdOut <= 1'b0;
            nrfdOe  <= 1'b0;
            ndacOut <= 1'b0;
            ndacOe  <= 1'b0;
            eoiOe   <= 1'b0;
            srqOut  <= 1'b0;
            srqOe   <= 1'b0;
        end else begin
            dioOe   <= talkActive && (srcState != SRC_IDLE);
            eoiOe   <= talkActive && (srcState != SRC_IDLE) && eoiOut;
            davOut  <= talkActive && (srcState == SRC_DAV);
            davOe   <= talkActive && (srcState == SRC_DAV);
            nrfdOut <= accActive && !(accState == ACC_READY && canAccept);
            nrfdOe  <= accActive && !(accState == ACC_READY && canAccept);
            ndacOut <= accActive && (accState == ACC_READY);
            ndacOe  <= accActive && (accState == ACC_READY);
            srqOut  <= controlled && spollByte[`IBD_SPOLL_RSV];
            srqOe   <= controlled && spollByte[`IBD_SPOLL_RSV];
        end
    end

    // Register writes; hardware set wins over software clear
    always @(posedge clk) begin
        if (rst) begin
            enable    <= 1'b0;
            talkOnly  <= 1'b0;
            busAddr   <= `IBD_ADDR_RESET;
            spollByte <= 8'h00;
            txData    <= 9'h000;
            txValid   <= 1'b0;
            irqStat   <= 6'h00;
            irqMask   <= 6'h00;
        end else begin
            if (busWrite) begin
                if (wb_adr_i == `IBD_REG_CTRL) begin
                    enable   <= wb_dat_i[`IBD_CTRL_ENABLE];
                    talkOnly <= wb_dat_i[`IBD_CTRL_TALKONLY];
                end else if (wb_adr_i == `IBD_REG_ADDR) begin
                    if (wb_dat_i[4:0] <= `IBD_ADDR_MAX)
                        busAddr <= wb_dat_i[4:0];
                end else if (wb_adr_i == `IBD_REG_TXDATA) begin
                    if (!txValid) begin
                        txData  <= wb_dat_i[8:0];
                        txValid <= 1'b1;
                    end
                end else if (wb_adr_i == `IBD_REG_SPOLL) begin
                    spollByte <= wb_dat_i[7:0];
                end else if (wb_adr_i == `IBD_REG_IRQMASK) begin
                    irqMask <= wb_dat_i[5:0];
                end
            end
            if (busWrite && wb_adr_i == `IBD_REG_IRQSTAT)
                irqStat <= (irqStat & ~wb_dat_i[5:0]) | evt;
            else
                irqStat <= irqStat | evt;
            if (srcDone && !srcSpoll)
                txValid <= 1'b0;
            if (srcDone && srcSpoll)
                spollByte[`IBD_SPOLL_RSV] <= 1'b0;
            if (devClear)
                txValid <= 1'b0;
        end
    end

    // Register reads; one-cycle ack, unmapped addresses read zero
    always @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            panelKeysEnabled <= 1'b1;
        end else begin
            wb_ack_o <= busReq;
            panelKeysEnabled <= !remote;
            if (busReq && !wb_we_i) begin
                if (wb_adr_i == `IBD_REG_CTRL)
                    wb_dat_o <= {30'h0, talkOnly, enable};
                else if (wb_adr_i == `IBD_REG_ADDR)
                    wb_dat_o <= {27'h0, busAddr};
                else if (wb_adr_i == `IBD_REG_STATE)
                    wb_dat_o <= {24'h0, txValid, rxValid, srqOut,
                                 spollMode, lockout, remote, listener,
                                 talker};
                else if (wb_adr_i == `IBD_REG_TXDATA)
                    wb_dat_o <= {23'h0, txData};
                else if (wb_adr_i == `IBD_REG_RXDATA)
                    wb_dat_o <= {24'h0, rxData};
                else if (wb_adr_i == `IBD_REG_SPOLL)
                    wb_dat_o <= {24'h0, spollByte};
                else if (wb_adr_i == `IBD_REG_IRQSTAT)
                    wb_dat_o <= {26'h0, irqStat};
                else if (wb_adr_i == `IBD_REG_IRQMASK)
                    wb_dat_o <= {26'h0, irqMask};
                else
                    wb_dat_o <= 32'h00000000;
            end
        end
    end

    assign irq = |(irqStat & irqMask);

endmodule

`default_nettype wire

// File: testbench/ibd_ctl_model.sv
/* Bus controller model on the device port's pins.
   Assumes true logic, wired-OR drivers, released lines false. */
`default_nettype none
module ibd_ctl_model (
    // Clock
    input  wire logic       clk,
    // Device drive
    input  wire logic [7:0] dioOut,
    input  wire logic       dioOe,
    input  wire logic       davOut,
    input  wire logic       davOe,
    input  wire logic       nrfdOut,
    input  wire logic       nrfdOe,
    input  wire logic       ndacOut,
    input  wire logic       ndacOe,
    input  wire logic       eoiOut,
    input  wire logic       eoiOe,
    // Resolved lines
    output wire logic [7:0] dioIn,
    output wire logic       davIn,
    output wire logic       nrfdIn,
    output wire logic       ndacIn,
    output wire logic       eoiIn,
    output wire logic       atnIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mDio, got;
    logic       mDav, mNrfd, mNdac, mAtn, gotEoi;
    int         gotN, slow;
    assign dioIn  = mDio | (dioOe ? dioOut : 8'h00);
    assign davIn  = mDav | (davOe & davOut);
    assign nrfdIn = mNrfd | (nrfdOe & nrfdOut);
    assign ndacIn = mNdac | (ndacOe & ndacOut);
    assign eoiIn  = eoiOe & eoiOut;
    assign atnIn  = mAtn;
    initial begin
        {mDio, mDav, mNrfd, mNdac, mAtn} = '0;
        {gotN, slow} = '0;
    end
    // Source role; data held until ndac is released
    task automatic send(input logic a, input logic [7:0] b);
        @(posedge clk);
        mAtn <= a;
        mDio <= b;
        repeat (3) @(posedge clk);
        while (nrfdIn) @(posedge clk);
        mDav <= 1'b1;
        repeat (6) @(posedge clk);
        while (ndacIn) @(posedge clk);
        mDav <= 1'b0;
        mDio <= 8'h00;
        repeat (6) @(posedge clk);
        mAtn <= 1'b0;
    endtask
    // Acceptor role; slow stretches the accept
    always begin
        @(posedge clk);
        if (davIn && !mDav) begin
            got <= dioIn;
            gotEoi <= eoiIn;
            gotN <= gotN + 1;
            mNrfd <= 1'b1;
            repeat (slow) @(posedge clk);
            mNdac <= 1'b1;
            repeat (4) @(posedge clk);
            mNdac <= 1'b0;
            while (davIn) @(posedge clk);
            mNrfd <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: testbench/ibd_port_monitor.sv
/* Pin and bus timing checker, bound into the device port.
   Assumes clk only, with synchronous active-high rst. */
`default_nettype none
module ibd_port_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Bus lines
    input wire logic dioOe,
    input wire logic davIn,
    input wire logic davOut,
    input wire logic davOe,
    input wire logic nrfdOut,
    input wire logic nrfdOe,
    input wire logic ndacOut,
    input wire logic ndacOe,
    input wire logic srqOut,
    input wire logic srqOe,
    input wire logic renIn,
    // Panel and display
    input wire logic sampleHold,
    input wire logic panelKeysEnabled,
    input wire logic displayRefresh
);
    timeunit 1ns;
    timeprecision 1ps;
    // Count starts one cycle after dioOe rises
    localparam int SETTLE = 79;
    logic [7:0] oeCnt;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    always @(posedge clk) begin
        if (rst || !dioOe) oeCnt <= 8'h00;
        else if (oeCnt != 8'hff) oeCnt <= oeCnt + 8'h01;
    end
    sequence busReq; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence renOff; !renIn [*5]; endsequence
    sequence davTaken; $past(davIn, 2) || $past(davIn, 3); endsequence
    ack_one_a: assert property (busReq |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle");
    dav_tie_a: assert property (davOut == davOe)
        else $error("dav enable mismatch");
    dav_data_a: assert property (davOut |-> dioOe && $stable(dioOe))
        else $error("dav without data");
    src_settle_a: assert property ($rose(davOut) |-> oeCnt >= SETTLE)
        else $error("dav before settle");
    lines_tie_a: assert property (nrfdOut == nrfdOe && ndacOut == ndacOe)
        else $error("handshake enable mismatch");
    acc_take_a: assert property ($rose(nrfdOut) |-> davTaken)
        else $error("take without dav");
    srq_tie_a: assert property (srqOut == srqOe)
        else $error("srq enable mismatch");
    ren_local_a: assert property (renOff |-> panelKeysEnabled)
        else $error("remote without ren");
    refresh_pulse_a: assert property (displayRefresh |=> !displayRefresh)
        else $error("refresh too long");
    refresh_hold_a: assert property (displayRefresh |-> $past(sampleHold))
        else $error("refresh without hold");
endmodule
`default_nettype wire

// File: testbench/tb.sv
/* Bench of the device port.
   Assumes the controller model and the bound checker. */
`include "ibd_defines.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, cyc, stb, we, ack, irq, refreshSeen;
    logic [7:0]  adr, dioIn, dioOut, sp;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, rv;
    logic        dioOe, davIn, davOut, davOe, nrfdIn, nrfdOut, nrfdOe;
    logic        ndacIn, ndacOut, ndacOe, eoiIn, eoiOut, eoiOe, srqOut;
    logic        srqOe, atnIn, ifcIn, renIn, localKey, displayTick;
    logic        sampleHold, keysOn, refresh;
    logic [4:0]  my, other;
    logic [8:0]  tx;
    int          n_fail, checks, n0;
    ibd_device_port ibd_device_port_inst (
        .clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq, .dioIn, .dioOut, .dioOe, .davIn, .davOut,
        .davOe, .nrfdIn, .nrfdOut, .nrfdOe, .ndacIn, .ndacOut, .ndacOe,
        .eoiIn, .eoiOut, .eoiOe, .srqOut, .srqOe, .atnIn, .ifcIn, .renIn,
        .localKey, .displayTick, .sampleHold, .panelKeysEnabled(keysOn),
        .displayRefresh(refresh));
    ibd_ctl_model ibd_ctl_model_inst (
        .clk, .dioOut, .dioOe, .davOut, .davOe, .nrfdOut, .nrfdOe,
        .ndacOut, .ndacOe, .eoiOut, .eoiOe, .dioIn, .davIn, .nrfdIn,
        .ndacIn, .eoiIn, .atnIn);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rv = rdat;
        if (n >= 50) n_fail++;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
        wb(1'b0, a, 32'h0);
        chk(rv & m, e);
    endtask
    task automatic send(input logic a, input logic [7:0] b);
        ibd_ctl_model_inst.send(a, b);
    endtask
    task automatic tk(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic st(input logic [31:0] m, e);
        rd(`IBD_REG_STATE, m, e);
    endtask
    task automatic clr();
        wb(1'b1, `IBD_REG_IRQSTAT, 32'h3f);
    endtask
    task automatic key();
        tk(1);
        localKey <= 1'b1;
        tk(1);
        localKey <= 1'b0;
        tk(4);
    endtask
    task automatic waitGot();
        int n;
        n = 0;
        while (ibd_ctl_model_inst.gotN == n0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n >= 400) n_fail++;
        tk(20);
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (refresh === 1'b1) refreshSeen <= 1'b1;
    end
    initial begin
        #(25 * 20000);
        n_fail++;
        end_of_test();
    end
    initial begin
        {rst, cyc, stb, we, ifcIn, renIn, localKey} = 7'h01 << 6;
        {displayTick, sampleHold, refreshSeen} = 3'h0;
        {adr, wdat, n_fail, checks} = '0;
        sel = 4'h1;
        void'($urandom(75));
        tk(6);
        rst <= 1'b0;
        my = 5'($urandom % 31);
        other = (my == 5'h1e) ? 5'h00 : my + 5'h01;
        rd(`IBD_REG_ADDR, 32'h1f, 32'h1);
        rd(`IBD_REG_CTRL, 32'h3, 32'h0);
        rd(8'h24, 32'hffffffff, 32'h0);
        wb(1'b1, `IBD_REG_ADDR, 32'h1f);
        rd(`IBD_REG_ADDR, 32'h1f, 32'h1);
        wb(1'b1, `IBD_REG_ADDR, {27'h0, my});
        rd(`IBD_REG_ADDR, 32'h1f, {27'h0, my});
        renIn <= 1'b1;
        send(1'b1, {`IBD_CMD_LISTEN, my});
        st(32'hf, 32'h0);
        wb(1'b1, `IBD_REG_CTRL, 32'h1);
        wb(1'b1, `IBD_REG_IRQMASK, 32'h3f);
        send(1'b1, {`IBD_CMD_LISTEN, other});
        st(32'hf, 32'h0);
        send(1'b1, {`IBD_CMD_LISTEN, my});
        st(32'hf, 32'h6);
        chk(keysOn, 0);
        rd(`IBD_REG_IRQSTAT, 32'h20, 32'h20);
        chk(irq, 1);
        clr();
        chk(irq, 0);
        key();
        st(32'h4, 32'h0);
        chk(keysOn, 1);
        send(1'b1, {`IBD_CMD_LISTEN, my});
        send(1'b1, `IBD_CMD_LLO);
        key();
        st(32'hc, 32'hc);
        send(1'b1, `IBD_CMD_GTL);
        st(32'h4, 32'h0);
        send(1'b1, `IBD_CMD_GET);
        chk(refreshSeen, 0);
        sampleHold <= 1'b1;
        send(1'b1, `IBD_CMD_GET);
        chk(refreshSeen, 1);
        sampleHold <= 1'b0;
        clr();
        send(1'b0, `IBD_ODR_CHAR0);
        rd(`IBD_REG_RXDATA, 32'hff, 32'h4f);
        send(1'b0, `IBD_ODR_CHAR1);
        rd(`IBD_REG_RXDATA, 32'hff, 32'h44);
        rd(`IBD_REG_IRQSTAT, 32'h5, 32'h5);
        wb(1'b1, `IBD_REG_IRQMASK, 32'h0);
        chk(irq, 0);
        wb(1'b1, `IBD_REG_IRQMASK, 32'h4);
        chk(irq, 1);
        clr();
        chk(irq, 0);
        send(1'b1, {`IBD_CMD_TALK, my});
        st(32'h3, 32'h1);
        tx = 9'($urandom);
        ibd_ctl_model_inst.slow = 5;
        n0 = ibd_ctl_model_inst.gotN;
        wb(1'b1, `IBD_REG_TXDATA, {23'h0, tx});
        waitGot();
        chk(ibd_ctl_model_inst.got, tx[7:0]);
        chk(ibd_ctl_model_inst.gotEoi, tx[8]);
        rd(`IBD_REG_IRQSTAT, 32'h2, 32'h2);
        send(1'b1, {`IBD_CMD_LISTEN, my});
        st(32'h3, 32'h2);
        sp = {2'b01, 6'($urandom)};
        ibd_ctl_model_inst.slow = 0;
        wb(1'b1, `IBD_REG_SPOLL, {24'h0, sp});
        tk(4);
        chk(srqOut, 1);
        send(1'b1, `IBD_CMD_SPE);
        n0 = ibd_ctl_model_inst.gotN;
        send(1'b1, {`IBD_CMD_TALK, my});
        waitGot();
        chk(ibd_ctl_model_inst.got, sp);
        send(1'b1, `IBD_CMD_SPD);
        chk(srqOut, 0);
        tk(1);
        ifcIn <= 1'b1;
        tk(4);
        ifcIn <= 1'b0;
        st(32'h3, 32'h0);
        wb(1'b1, `IBD_REG_TXDATA, 32'h55);
        st(32'h80, 32'h80);
        send(1'b1, `IBD_CMD_DCL);
        st(32'h80, 32'h0);
        rd(`IBD_REG_IRQSTAT, 32'h8, 32'h8);
        rd(`IBD_REG_ADDR, 32'h1f, {27'h0, my});
        wb(1'b1, `IBD_REG_CTRL, 32'h3);
        clr();
        tk(1);
        displayTick <= 1'b1;
        tk(1);
        displayTick <= 1'b0;
        rd(`IBD_REG_IRQSTAT, 32'h4, 32'h4);
        send(1'b1, {`IBD_CMD_LISTEN, my});
        st(32'h2, 32'h0);
        tx = {1'b1, 8'($urandom)};
        n0 = ibd_ctl_model_inst.gotN;
        wb(1'b1, `IBD_REG_TXDATA, {23'h0, tx});
        waitGot();
        chk(ibd_ctl_model_inst.got, tx[7:0]);
        renIn <= 1'b0;
        tk(8);
        chk(keysOn, 1);
        end_of_test();
    end
endmodule
bind ibd_device_port ibd_port_monitor ibd_port_monitor_inst (
    .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .dioOe, .davIn, .davOut,
    .davOe, .nrfdOut, .nrfdOe, .ndacOut, .ndacOe, .srqOut, .srqOe, .renIn,
    .sampleHold, .panelKeysEnabled, .displayRefresh);
`default_nettype wire
